// File: rtl/scw_pkg.sv
// Shared constants and types for the system counter and wakeup timer block
package scw_pkg;

  localparam int NUM_CORES = 8;
  localparam int COUNT_W = 64;
  localparam int COUNT_MIN_W = 56;
  localparam int NUM_SW_IRQ = 8;
  localparam int NUM_AOW = 2;

  localparam longint CLOCK_HZ = 10_000_000;
  localparam longint RATE_MIN_HZ = 10_000_000;
  localparam longint RATE_MAX_HZ = 400_000_000;
  localparam int TICK_CYCLES = (CLOCK_HZ / CLOCK_HZ > 0) ? int'(CLOCK_HZ / CLOCK_HZ) : 1;

  localparam logic [COUNT_W-1:0] COUNT_RESET = 64'h0000_0000_0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_STEP = 64'h0000_0000_0000_0001;
  localparam logic [NUM_CORES-1:0] CORES_NONE = 8'h00;
  localparam int AOW_PCIE = 0;
  localparam int AOW_LAN = 1;

  typedef logic [COUNT_W-1:0] scw_count_t;

  typedef enum logic [1:0] {
    WT_IDLE = 2'b00,
    WT_ARMED = 2'b01,
    WT_FIRED = 2'b10
  } scw_wt_state_e;

  // Pending and distributor-enable bits of one core's wakeup sources
  typedef struct packed {
    logic spiTargeted;
    logic spiEnabled;
    logic [NUM_SW_IRQ-1:0] swIrqPending;
    logic [NUM_SW_IRQ-1:0] swIrqEnabled;
    logic privIrqPending;
    logic privIrqEnabled;
  } scw_wake_src_s;

  // Local timer programming for one core
  typedef struct packed {
    scw_count_t compareValue;
    logic timerEnable;
    logic timerPowered;
  } scw_ltimer_cfg_s;

  function automatic logic scw_wake_qualify(input scw_wake_src_s src);
    scw_wake_qualify = (src.spiTargeted & src.spiEnabled) | (|(src.swIrqPending & src.swIrqEnabled))
                       | (src.privIrqPending & src.privIrqEnabled);
  endfunction : scw_wake_qualify

endpackage : scw_pkg

// File: rtl/scw_local_timer.sv
// Per-core local timer comparing the distributed system count
`timescale 1ns/1ps
`default_nettype none
module scw_local_timer (
  input wire logic clock, // 10 MHz clock
  input wire logic sys_rst, // Async reset, active high
  input wire scw_pkg::scw_count_t sysCount, // Distributed count
  input wire scw_pkg::scw_ltimer_cfg_s cfg, // Compare, enable, power
  output logic privIrq_q // Private interrupt level
);
  import scw_pkg::*;

  logic expired;

  // Powered-down timer sees no count and stays quiet
  assign expired = cfg.timerPowered && cfg.timerEnable && (sysCount >= cfg.compareValue);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      privIrq_q <= 1'b0;
    end else begin
      privIrq_q <= expired;
    end
  end

  priv_irq_set_a: assert property (@(posedge clock) disable iff (sys_rst)
    cfg.timerPowered && cfg.timerEnable && sysCount >= cfg.compareValue |=> privIrq_q)
    else $error("local timer did not raise its private interrupt on expiry");

  priv_irq_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    !cfg.timerPowered |=> !privIrq_q)
    else $error("unpowered local timer raised an interrupt");

endmodule : scw_local_timer
`default_nettype wire

// File: rtl/scw_top.sv
// System counter, local timers, wakeup timer and wake routing
// Behaviour
// - Counter advances once per clock at 10 MHz, inside the 10-400 MHz band.
// - Counter is 64 bits wide, within the 56 to 64 bit range.
// - Width and start value chosen so the count never wraps in practice.
// - Count reaches every local timer while that core's timer is powered.
// - Local timer raises its core's private interrupt when compare value expires.
// - Wakeup timer lives in always-on logic, working while local timers are off.
// - Wakeup timer expiry drives a level shared interrupt to the distributor.
// - Wakeup interrupt: targeted shared, any software, or private, and distributor-enabled; local timer and perf overflow need no enable.
// - Wake ignores core interrupt mask bits and interrupt priority.
// - Software-generated interrupts 0-7 are all provided per core.
// - Power controller programmable to wake cores on wakeup timer expiry.
// - Wakeup timer still asserts its interrupt when power controller wakes cores.
// - Always-on events such as PCI Express wake or network wake may wake cores.
// - Performance monitor overflow reaches its own private interrupt with no logic.
// - Distributor exports a wake request to the power controller.
// - With distributor off, timer expiry wakes the chosen core group.
`timescale 1ns/1ps
`default_nettype none
module scw_top (
  input wire logic clock, // 10 MHz clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic counterLoad, // Pulse: load start value
  input wire scw_pkg::scw_count_t counterStart, // Programmed start value
  input wire scw_pkg::scw_ltimer_cfg_s [scw_pkg::NUM_CORES-1:0] ltimerCfg, // Local timer setup
  input wire scw_pkg::scw_wake_src_s [scw_pkg::NUM_CORES-1:0] wakeSrc, // Distributor wake sources
  input wire logic [scw_pkg::NUM_CORES-1:0] perfOverflow, // Perf monitor overflow per core
  input wire scw_pkg::scw_count_t wakeCompare, // Wakeup timer compare
  input wire logic wakeEnable, // Wakeup timer enable
  input wire logic wakeProgram, // Pulse: wakeup timer rewritten
  input wire logic distOff, // Distributor powered down
  input wire logic pcWakeOnTimer, // Power ctrl wakes on timer
  input wire logic [scw_pkg::NUM_CORES-1:0] pcWakeTarget, // Cores woken by timer
  input wire logic [scw_pkg::NUM_AOW-1:0] aowEvent, // Always-on wake events
  input wire logic [scw_pkg::NUM_AOW-1:0] aowEnable, // Always-on event enables
  input wire logic [scw_pkg::NUM_CORES-1:0] aowTarget, // Cores woken by events
  input wire logic msiRequest, // Message interrupt toward distributor
  output logic [scw_pkg::COUNT_W-1:0] sysCount_q, // Distributed count
  output logic [scw_pkg::NUM_CORES-1:0] countLive_q, // Count valid for core
  output logic [scw_pkg::NUM_CORES-1:0] privTimerIrq, // Local timer interrupts
  output logic [scw_pkg::NUM_CORES-1:0] perfIrq, // Perf overflow interrupts
  output logic wakeIrq_q, // Shared level interrupt
  output logic [scw_pkg::NUM_CORES-1:0] wakeReq_q, // Distributor wake request
  output logic [scw_pkg::NUM_CORES-1:0] coreWake_q, // Power ctrl wake pulse
  output logic msiBlocked_q // Message dropped, dist off
);
  import scw_pkg::*;

  scw_wt_state_e wtState_q;
  scw_wt_state_e wtState_d;
  logic expiryHit;
  logic [NUM_CORES-1:0] wakeQual;
  logic aowHit;

  // Free-running counter; 64 bits at 10 MHz lasts far beyond any service life
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sysCount_q <= COUNT_RESET;
    end else if (counterLoad) begin
      sysCount_q <= counterStart;
    end else begin
      sysCount_q <= sysCount_q + COUNT_STEP;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      countLive_q <= CORES_NONE;
    end else begin
      for (int i = 0; i < NUM_CORES; i++) begin
        countLive_q[i] <= ltimerCfg[i].timerPowered;
      end
    end
  end

  // Pure wires: any gating here would delay or mask the overflow
  assign perfIrq = perfOverflow;

  genvar c;
  generate
    for (c = 0; c < NUM_CORES; c++) begin : g_core
      scw_local_timer u_ltimer (
        .clock(clock),
        .sys_rst(sys_rst),
        .sysCount(sysCount_q),
        .cfg(ltimerCfg[c]),
        .privIrq_q(privTimerIrq[c])
      );
      // Masks and priority are deliberately not inputs here
      assign wakeQual[c] = scw_wake_qualify(wakeSrc[c]) | privTimerIrq[c] | perfOverflow[c];

      wake_req_a: assert property (@(posedge clock) disable iff (sys_rst)
        !distOff && wakeQual[c] |=> wakeReq_q[c])
        else $error("qualified wake interrupt gave no wake request");

      count_live_a: assert property (@(posedge clock) disable iff (sys_rst)
        ltimerCfg[c].timerPowered |=> countLive_q[c])
        else $error("powered local timer not marked as receiving the count");
    end
  endgenerate

  // Wakeup timer, always on
  always_comb begin
    expiryHit = 1'b0;
    wtState_d = wtState_q;
    unique case (wtState_q)
      WT_IDLE: begin
        if (wakeEnable) begin
          wtState_d = WT_ARMED;
        end
      end
      WT_ARMED: begin
        if (!wakeEnable) begin
          wtState_d = WT_IDLE;
        end else if (!wakeProgram && sysCount_q >= wakeCompare) begin
          expiryHit = 1'b1;
          wtState_d = WT_FIRED;
        end
      end
      WT_FIRED: begin
        if (!wakeEnable) begin
          wtState_d = WT_IDLE;
        end else if (wakeProgram) begin
          wtState_d = WT_ARMED;
        end
      end
      default: begin
        wtState_d = WT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wtState_q <= WT_IDLE;
    end else begin
      wtState_q <= wtState_d;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wakeIrq_q <= 1'b0;
    end else begin
      wakeIrq_q <= (wtState_d == WT_FIRED);
    end
  end

  // Distributor-side wake request, only meaningful while it is powered
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wakeReq_q <= CORES_NONE;
    end else begin
      wakeReq_q <= distOff ? CORES_NONE : wakeQual;
    end
  end

  assign aowHit = |(aowEvent & aowEnable);

  // Power controller path: timer wake in distributor-off states, always-on events in any state
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      coreWake_q <= CORES_NONE;
    end else begin
      coreWake_q <= ((distOff && pcWakeOnTimer && expiryHit) ? pcWakeTarget : CORES_NONE)
                    | (aowHit ? aowTarget : CORES_NONE);
    end
  end

  // A powered-down distributor cannot take message interrupts; flag the offender
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      msiBlocked_q <= 1'b0;
    end else begin
      msiBlocked_q <= distOff && msiRequest;
    end
  end

  counter_step_a: assert property (@(posedge clock) disable iff (sys_rst)
    !counterLoad |=> sysCount_q == $past(sysCount_q) + COUNT_STEP)
    else $error("system counter did not advance by one");

  counter_load_a: assert property (@(posedge clock) disable iff (sys_rst)
    counterLoad |=> sysCount_q == $past(counterStart))
    else $error("system counter did not take its start value");

  wake_irq_set_a: assert property (@(posedge clock) disable iff (sys_rst)
    wtState_q == WT_ARMED && wakeEnable && !wakeProgram && sysCount_q >= wakeCompare |=> wakeIrq_q)
    else $error("wakeup timer expiry did not raise the shared interrupt");

  wake_irq_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    wakeIrq_q && wakeEnable && !wakeProgram |=> wakeIrq_q)
    else $error("wakeup interrupt dropped without reprogram or disable");

  wake_irq_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    !wakeEnable |=> !wakeIrq_q)
    else $error("wakeup interrupt stayed up with timer disabled");

  pc_timer_wake_a: assert property (@(posedge clock) disable iff (sys_rst)
    distOff && pcWakeOnTimer && expiryHit |=> (coreWake_q & $past(pcWakeTarget)) == $past(pcWakeTarget))
    else $error("power controller did not wake target cores on timer expiry");

  pc_irq_kept_a: assert property (@(posedge clock) disable iff (sys_rst)
    distOff && pcWakeOnTimer && expiryHit |=> wakeIrq_q
      ##1 (wakeIrq_q || !$past(wakeEnable) || $past(wakeProgram)))
    else $error("wakeup interrupt missing while power controller wakes cores");

  aow_wake_a: assert property (@(posedge clock) disable iff (sys_rst)
    (|(aowEvent & aowEnable)) |=> (coreWake_q & $past(aowTarget)) == $past(aowTarget))
    else $error("always-on event did not wake its target cores");

  msi_block_a: assert property (@(posedge clock) disable iff (sys_rst)
    distOff && msiRequest |=> msiBlocked_q)
    else $error("message interrupt toward powered-down distributor not flagged");

  wake_req_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    distOff |=> wakeReq_q == CORES_NONE)
    else $error("wake request raised while distributor is off");

  timer_wake_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    !distOff && !aowHit |=> coreWake_q == CORES_NONE)
    else $error("power controller woke cores with distributor on and no event");

endmodule : scw_top
`default_nettype wire

// File: tb/scw_partner.sv
// Distributor and device side model driving wake sources and message requests
`timescale 1ns/1ps
`default_nettype none
module scw_partner (
  input wire logic distOff, // Distributor powered down
  input wire logic [1:0] kind, // 0 none, 1 shared, 2 software, 3 private
  input wire logic [2:0] core, // Targeted core
  input wire logic [2:0] swIrqNo, // Software interrupt number
  input wire logic srcEnable, // Distributor enable of the source
  input wire logic noWake, // Target core cannot wake
  input wire logic msiTry, // Device wants to send a message
  input wire logic msiMisuse, // Send even while distributor is off
  output scw_pkg::scw_wake_src_s [scw_pkg::NUM_CORES-1:0] wakeSrc, // Wake sources
  output logic msiRequest // Message toward distributor
);
  import scw_pkg::*;
  always_comb begin
    wakeSrc = '0;
    // Nothing aimed at a core that cannot wake
    if (!noWake) begin
      wakeSrc[core].spiTargeted = (kind == 2'h1);
      wakeSrc[core].spiEnabled = srcEnable;
      wakeSrc[core].swIrqPending[swIrqNo] = (kind == 2'h2);
      wakeSrc[core].swIrqEnabled = {NUM_SW_IRQ{srcEnable}};
      wakeSrc[core].privIrqPending = (kind == 2'h3);
      wakeSrc[core].privIrqEnabled = srcEnable;
    end
  end
  assign msiRequest = msiTry & (~distOff | msiMisuse);
endmodule : scw_partner
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the system counter and wakeup timer block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scw_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic counterLoad = 1'b0, wakeEnable = 1'b0, wakeProgram = 1'b0, distOff = 1'b0, pcWakeOnTimer = 1'b0;
  scw_count_t counterStart = '0, wakeCompare = '0;
  scw_ltimer_cfg_s [NUM_CORES-1:0] ltimerCfg = '0;
  scw_wake_src_s [NUM_CORES-1:0] wakeSrc;
  logic [7:0] perfOverflow = '0, pcWakeTarget = '0, aowTarget = '0;
  logic [1:0] aowEvent = '0, aowEnable = '0, kind = '0;
  logic [2:0] core = '0, swIrqNo = '0;
  logic srcEnable = 1'b0, noWake = 1'b0, msiTry = 1'b0, msiMisuse = 1'b0, msiRequest, wakeIrq_q, msiBlocked_q;
  logic [63:0] sysCount_q;
  logic [7:0] countLive_q, privTimerIrq, perfIrq, wakeReq_q, coreWake_q;
  logic [31:0] lfsrState = 32'h25;
  int error_cnt = 0, checked = 0, cycles = 0, c;
  int qs[$];
  logic [63:0] qe[$];
  string nm[8] = '{"sysCount", "countLive", "privTimerIrq", "wakeIrq", "wakeReq", "coreWake", "msiBlocked", "perfIrq"};
  scw_partner partner (.distOff(distOff), .kind(kind), .core(core), .swIrqNo(swIrqNo), .srcEnable(srcEnable),
    .noWake(noWake), .msiTry(msiTry), .msiMisuse(msiMisuse), .wakeSrc(wakeSrc), .msiRequest(msiRequest));
  scw_top uut (.clock(clock), .sys_rst(sys_rst), .counterLoad(counterLoad), .counterStart(counterStart),
    .ltimerCfg(ltimerCfg), .wakeSrc(wakeSrc), .perfOverflow(perfOverflow), .wakeCompare(wakeCompare),
    .wakeEnable(wakeEnable), .wakeProgram(wakeProgram), .distOff(distOff), .pcWakeOnTimer(pcWakeOnTimer),
    .pcWakeTarget(pcWakeTarget), .aowEvent(aowEvent), .aowEnable(aowEnable), .aowTarget(aowTarget),
    .msiRequest(msiRequest), .sysCount_q(sysCount_q), .countLive_q(countLive_q), .privTimerIrq(privTimerIrq),
    .perfIrq(perfIrq), .wakeIrq_q(wakeIrq_q), .wakeReq_q(wakeReq_q), .coreWake_q(coreWake_q),
    .msiBlocked_q(msiBlocked_q));
  initial forever #50 clock = ~clock;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [63:0] outv(input int s);
    case (s)
      0: return sysCount_q;
      1: return {56'h0, countLive_q};
      2: return {56'h0, privTimerIrq};
      3: return {63'h0, wakeIrq_q};
      4: return {56'h0, wakeReq_q};
      5: return {56'h0, coreWake_q};
      6: return {63'h0, msiBlocked_q};
      default: return {56'h0, perfIrq};
    endcase
  endfunction : outv
  task automatic chk(input string n, input logic [63:0] exp, input logic [63:0] seen);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // A note is judged just after the next rising edge
  task automatic note(input int s, input logic [63:0] e);
    qs.push_back(s);
    qe.push_back(e);
  endtask : note
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  always @(posedge clock) begin
    #1;
    while (qs.size() > 0) begin
      chk(nm[qs[0]], qe[0], outv(qs[0]));
      void'(qs.pop_front());
      void'(qe.pop_front());
    end
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      $display("mismatch timeout expected 0 seen 1");
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    @(negedge clock) sys_rst = 1'b0;
    note(0, 64'h1);
    @(negedge clock) lfsrState = lfsr(lfsrState);
    counterStart = {32'h0, lfsrState};
    counterLoad = 1'b1;
    note(0, counterStart);
    @(negedge clock) counterLoad = 1'b0;
    note(0, counterStart + 64'h1);
    $display("test counter done");
    @(negedge clock) c = lfsrState[2:0];
    ltimerCfg[c] = '{compareValue: counterStart + 64'd40, timerEnable: 1'b1, timerPowered: 1'b1};
    note(1, 64'h1 << c);
    note(2, 64'h0);
    // Count is start+1 here, so the compare is met 39 edges on
    repeat (38) @(negedge clock);
    note(2, 64'h0);
    @(negedge clock) note(2, 64'h1 << c);
    @(negedge clock) ltimerCfg[c] = '0;
    note(2, 64'h0);
    note(1, 64'h0);
    $display("test local timer done");
    @(negedge clock) lfsrState = lfsr(lfsrState);
    pcWakeTarget = lfsrState[7:0];
    {distOff, pcWakeOnTimer, wakeEnable} = 3'b111;
    wakeCompare = counterStart;
    note(3, 64'h0);
    @(negedge clock) note(3, 64'h1);
    note(5, {56'h0, pcWakeTarget});
    @(negedge clock) note(3, 64'h1);
    note(5, 64'h0);
    @(negedge clock) wakeCompare = '1;
    wakeProgram = 1'b1;
    note(3, 64'h0);
    @(negedge clock) wakeProgram = 1'b0;
    wakeCompare = counterStart;
    pcWakeOnTimer = 1'b0;
    note(3, 64'h1);
    note(5, 64'h0);
    @(negedge clock) wakeEnable = 1'b0;
    note(3, 64'h0);
    $display("test wakeup timer done");
    @(negedge clock) distOff = 1'b0;
    srcEnable = 1'b1;
    for (int i = 0; i < 10; i++) begin
      lfsrState = lfsr(lfsrState);
      core = lfsrState[2:0];
      swIrqNo = i[2:0];
      kind = (i < 8) ? 2'h2 : ((i == 8) ? 2'h1 : 2'h3);
      note(4, 64'h1 << core);
      @(negedge clock);
    end
    srcEnable = 1'b0;
    note(4, 64'h0);
    @(negedge clock) srcEnable = 1'b1;
    noWake = 1'b1;
    note(4, 64'h0);
    @(negedge clock) noWake = 1'b0;
    distOff = 1'b1;
    note(4, 64'h0);
    @(negedge clock) kind = 2'h0;
    lfsrState = lfsr(lfsrState);
    perfOverflow = lfsrState[7:0];
    #1 chk("perfIrq", {56'h0, perfOverflow}, {56'h0, perfIrq});
    $display("test wake request done");
    for (int i = 0; i < 2; i++) begin
      @(negedge clock) perfOverflow = '0;
      lfsrState = lfsr(lfsrState);
      aowTarget = lfsrState[7:0];
      aowEvent = 2'b01 << i;
      aowEnable = aowEvent;
      note(5, {56'h0, aowTarget});
      @(negedge clock) aowEnable = 2'b00;
      note(5, 64'h0);
    end
    @(negedge clock) aowEvent = 2'b00;
    msiTry = 1'b1;
    msiMisuse = 1'b1;
    note(6, 64'h1);
    @(negedge clock) msiMisuse = 1'b0;
    note(6, 64'h0);
    @(negedge clock) msiTry = 1'b0;
    @(negedge clock) $display("test wake events done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
